// File: gpio_pkg.sv
// Constants and carrier types for the LCD-shared port block
package gpio_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] SIX_DATA_IDX    = 10'h007;
  localparam logic [9:0] MIXED_DATA_IDX  = 10'h008;
  localparam logic [9:0] IN_ONE_DATA_IDX = 10'h009;
  localparam logic [9:0] SIX_DIR_IDX     = 10'h087;
  localparam logic [9:0] MIXED_DIR_IDX   = 10'h088;
  localparam logic [9:0] IN_ONE_DIR_IDX  = 10'h089;
  localparam logic [9:0] LCD_SE_IDX      = 10'h10d;
  localparam logic [9:0] IN_TWO_DATA_IDX = 10'h107;
  localparam logic [9:0] IN_TWO_DIR_IDX  = 10'h187;
  // ==========================================================
  // Reset values
  localparam logic [5:0] SIX_DATA_POR  = 6'h00;
  localparam logic [5:0] SIX_DIR_RST   = 6'h3f;
  localparam logic [7:0] MIXED_DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'hff;
  localparam logic [7:0] LCD_SE_RST    = 8'hff;
  // ==========================================================
  // Group select bit feeding each pin, three bits per pin, pin 0 lowest
  localparam logic [23:0] MIXED_GRP_MAP  = {3'h7, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  localparam logic [23:0] IN_ONE_GRP_MAP = {3'h6, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1};
  localparam logic [23:0] IN_TWO_GRP_MAP = {3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3};
  localparam int MIXED_GPIO_PINS = 5;
  // ==========================================================
  // Peripheral control and peripheral input carriers
  typedef struct packed {
    logic timer_osc_en;
    logic ccp_capture_en;
    logic ccp_out_en;
    logic ccp_out;
    logic ssp_en;
    logic ssp_i2c;
    logic sck_drive;
    logic sck_out;
    logic sda_drive_low;
    logic serial_data_out_pin;
  } periph_ctrl_type;
  typedef struct packed {
    logic timer_ext_clock_in;
    logic timer_osc_in;
    logic capture_in;
    logic sck_in;
    logic serial_data_in_pin;
  } periph_in_type;
endpackage

// File: lcd_port_io.sv
// Four ports: six-pin, plus the LCD-shared mixed and two input-only ports
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Six-pin data and direction bits 7 and 6 always read zero
// R02 - Power-on: six-pin direction all ones; other resets keep six-pin data
// R03 - Six-pin pins 0 and 1 serve the timer oscillator and clock
// R04 - Six-pin pin 2 is capture input, compare or PWM output
// R05 - Six-pin pin 3 carries serial clock when serial port enabled
// R06 - Pin 4 is SPI data in or I2C bidirectional data
// R07 - Pin 5 is serial data out when selected
// R08 - Mixed port is eight bits; lower five pins are I/O or segments
// R09 - Mixed direction drives only pins 0 to 4; pins 5 to 7 inputs
// R10 - Mixed pins 5 to 7 are inputs, segments or commons
// R11 - Segment-enable resets to all ones; shared pins start as LCD
// R12 - Software clears segment-enable bits before digital use
// R13 - Set segment-enable bit overrides direction bits of its pins
// R14 - Mixed data resets to zero, direction to ones, every reset
// R15 - First input port: eight inputs, no drive, LCD shared
// R16 - First input pins 0-6 segments 5-11, pin 7 segment 27
// R17 - Second input port: eight inputs selected by segment-enable
// R18 - Second input pins 0 to 7 map to segments 12 to 19
// R19 - Port read returns pin levels; write loads only output latch
// R20 - Each segment-enable bit except bit 5 selects a fixed contiguous pin group; bit 5 selects no pins
// R21 - Enabled peripheral overrides direction of its shared pins
module lcd_port_io (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      other_reset_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [5:0]                six_pin_in,
  output logic      [5:0]                six_pin_out,
  output logic      [5:0]                six_pin_oe,
  input  wire logic [7:0]                mixed_pin_in,
  output logic      [7:0]                mixed_pin_out,
  output logic      [7:0]                mixed_pin_oe,
  input  wire logic [7:0]                input_one_pin_in,
  input  wire logic [7:0]                input_two_pin_in,
  input  wire gpio_pkg::periph_ctrl_type periph_ctrl,
  output gpio_pkg::periph_in_type        periph_in,
  output logic      [7:0]                mixed_lcd_sel,
  output logic      [7:0]                input_one_lcd_sel,
  output logic      [7:0]                input_two_lcd_sel
);
  // ==========================================================
  // State
  logic [5:0]  six_data_reg;
  logic [5:0]  six_dir_reg;
  logic [7:0]  mixed_data_reg;
  logic [7:0]  mixed_dir_reg;
  logic [7:0]  in_one_dir_reg;
  logic [7:0]  in_two_dir_reg;
  logic [7:0]  lcd_se_reg;
  logic [29:0] sync1_reg;
  logic [29:0] sync2_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [5:0]  six_out_reg;
  logic [5:0]  six_oe_reg;
  logic [7:0]  mixed_out_reg;
  logic [7:0]  mixed_oe_reg;
  logic [7:0]  mixed_sel_reg;
  logic [7:0]  in_one_sel_reg;
  logic [7:0]  in_two_sel_reg;
  logic [4:0]  periph_in_reg;
  // ==========================================================
  // Pin synchronisers
  wire  [29:0] pin_raw = {input_two_pin_in, input_one_pin_in, mixed_pin_in, six_pin_in};
  wire  [5:0]  six_lvl = sync2_reg[5:0];
  wire  [7:0]  mixed_lvl = sync2_reg[13:6];
  wire  [7:0]  in_one_lvl = sync2_reg[21:14];
  wire  [7:0]  in_two_lvl = sync2_reg[29:22];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  // ==========================================================
  // APB decode
  wire [9:0] idx = paddr[11:2];
  wire       aligned = (paddr[1:0] == 2'h0);
  wire hit_six_data = aligned && (idx == gpio_pkg::SIX_DATA_IDX);
  wire hit_mixed_data = aligned && (idx == gpio_pkg::MIXED_DATA_IDX);
  wire hit_in_one_data = aligned && (idx == gpio_pkg::IN_ONE_DATA_IDX);
  wire hit_in_two_data = aligned && (idx == gpio_pkg::IN_TWO_DATA_IDX);
  wire hit_six_dir = aligned && (idx == gpio_pkg::SIX_DIR_IDX);
  wire hit_mixed_dir = aligned && (idx == gpio_pkg::MIXED_DIR_IDX);
  wire hit_in_one_dir = aligned && (idx == gpio_pkg::IN_ONE_DIR_IDX);
  wire hit_in_two_dir = aligned && (idx == gpio_pkg::IN_TWO_DIR_IDX);
  wire hit_lcd_se = aligned && (idx == gpio_pkg::LCD_SE_IDX);
  wire hit_any = hit_six_data || hit_mixed_data || hit_in_one_data || hit_in_two_data
               || hit_six_dir || hit_mixed_dir || hit_in_one_dir || hit_in_two_dir
               || hit_lcd_se;
  wire setup_ph = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  // Read mux: data registers show pin levels, upper bits zero
  logic [31:0] rd_next;
  always_comb begin
    rd_next = '0;
    if (hit_six_data) begin
      rd_next[5:0] = six_lvl; // R01 R19
    end else if (hit_mixed_data) begin
      rd_next[7:0] = mixed_lvl; // R19
    end else if (hit_in_one_data) begin
      rd_next[7:0] = in_one_lvl; // R15
    end else if (hit_in_two_data) begin
      rd_next[7:0] = in_two_lvl; // R17
    end else if (hit_six_dir) begin
      rd_next[5:0] = six_dir_reg; // R01
    end else if (hit_mixed_dir) begin
      rd_next[7:0] = mixed_dir_reg;
    end else if (hit_in_one_dir) begin
      rd_next[7:0] = in_one_dir_reg;
    end else if (hit_in_two_dir) begin
      rd_next[7:0] = in_two_dir_reg;
    end else if (hit_lcd_se) begin
      rd_next[7:0] = lcd_se_reg;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
      pslverr_reg <= !hit_any;
    end
  end
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg && psel && penable;
  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      six_data_reg   <= gpio_pkg::SIX_DATA_POR;
      six_dir_reg    <= gpio_pkg::SIX_DIR_RST; // R02
      mixed_data_reg <= gpio_pkg::MIXED_DATA_RST; // R14
      mixed_dir_reg  <= gpio_pkg::DIR_RST; // R14
      in_one_dir_reg <= gpio_pkg::DIR_RST;
      in_two_dir_reg <= gpio_pkg::DIR_RST;
      lcd_se_reg     <= gpio_pkg::LCD_SE_RST; // R11
    end else if (!other_reset_n) begin
      six_dir_reg    <= gpio_pkg::SIX_DIR_RST; // R02
      mixed_data_reg <= gpio_pkg::MIXED_DATA_RST; // R14
      mixed_dir_reg  <= gpio_pkg::DIR_RST; // R14
      in_one_dir_reg <= gpio_pkg::DIR_RST;
      in_two_dir_reg <= gpio_pkg::DIR_RST;
      lcd_se_reg     <= gpio_pkg::LCD_SE_RST; // R11
    end else if (wr_en) begin
      if (hit_six_data) begin
        six_data_reg <= pwdata[5:0]; // R19
      end
      if (hit_mixed_data) begin
        mixed_data_reg <= pwdata[7:0]; // R19
      end
      if (hit_six_dir) begin
        six_dir_reg <= pwdata[5:0];
      end
      if (hit_mixed_dir) begin
        mixed_dir_reg <= pwdata[7:0];
      end
      if (hit_in_one_dir) begin
        in_one_dir_reg <= pwdata[7:0];
      end
      if (hit_in_two_dir) begin
        in_two_dir_reg <= pwdata[7:0];
      end
      if (hit_lcd_se) begin
        lcd_se_reg <= pwdata[7:0];
      end
    end
  end
  // ==========================================================
  // LCD group selects, one per pin
  logic [7:0] mixed_sel_next;
  logic [7:0] in_one_sel_next;
  logic [7:0] in_two_sel_next;
  for (genvar i = 0; i < 8; i++) begin : g_grp
    assign mixed_sel_next[i] = lcd_se_reg[gpio_pkg::MIXED_GRP_MAP[3*i +: 3]]; // R10 R20
    assign in_one_sel_next[i] = lcd_se_reg[gpio_pkg::IN_ONE_GRP_MAP[3*i +: 3]]; // R16
    assign in_two_sel_next[i] = lcd_se_reg[gpio_pkg::IN_TWO_GRP_MAP[3*i +: 3]]; // R18
  end
  // ==========================================================
  // Mixed port drive
  logic [7:0] mixed_oe_next;
  for (genvar j = 0; j < 8; j++) begin : g_mix
    if (j < gpio_pkg::MIXED_GPIO_PINS) begin : g_io
      assign mixed_oe_next[j] = !mixed_dir_reg[j] && !mixed_sel_next[j]; // R08 R13
    end else begin : g_in
      assign mixed_oe_next[j] = 1'b0; // R09
    end
  end
  // ==========================================================
  // Six-pin port drive with peripheral overrides
  wire spi_on = periph_ctrl.ssp_en && !periph_ctrl.ssp_i2c;
  wire i2c_on = periph_ctrl.ssp_en && periph_ctrl.ssp_i2c;
  logic [5:0] six_oe_next;
  logic [5:0] six_out_next;
  assign six_oe_next[0] = periph_ctrl.timer_osc_en ? 1'b0 : !six_dir_reg[0]; // R03 R21
  assign six_oe_next[1] = periph_ctrl.timer_osc_en ? 1'b0 : !six_dir_reg[1]; // R03 R21
  assign six_oe_next[2] = periph_ctrl.ccp_out_en ? 1'b1
                        : periph_ctrl.ccp_capture_en ? 1'b0 : !six_dir_reg[2]; // R04 R21
  assign six_oe_next[3] = periph_ctrl.ssp_en ? periph_ctrl.sck_drive : !six_dir_reg[3]; // R05
  assign six_oe_next[4] = spi_on ? 1'b0
                        : i2c_on ? periph_ctrl.sda_drive_low : !six_dir_reg[4]; // R06 R21
  assign six_oe_next[5] = spi_on ? 1'b1 : !six_dir_reg[5]; // R07 R21
  assign six_out_next[1:0] = six_data_reg[1:0];
  assign six_out_next[2] = periph_ctrl.ccp_out_en ? periph_ctrl.ccp_out : six_data_reg[2];
  assign six_out_next[3] = periph_ctrl.ssp_en ? periph_ctrl.sck_out : six_data_reg[3]; // R05
  assign six_out_next[4] = i2c_on ? 1'b0 : six_data_reg[4]; // R06
  assign six_out_next[5] = spi_on ? periph_ctrl.serial_data_out_pin : six_data_reg[5]; // R07
  // ==========================================================
  // Registered pin outputs and peripheral inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      six_out_reg    <= '0;
      six_oe_reg     <= '0;
      mixed_out_reg  <= '0;
      mixed_oe_reg   <= '0;
      mixed_sel_reg  <= gpio_pkg::LCD_SE_RST; // R11
      in_one_sel_reg <= gpio_pkg::LCD_SE_RST; // R11
      in_two_sel_reg <= gpio_pkg::LCD_SE_RST; // R11
      periph_in_reg  <= '0;
    end else begin
      six_out_reg    <= six_out_next;
      six_oe_reg     <= six_oe_next;
      mixed_out_reg  <= mixed_data_reg;
      mixed_oe_reg   <= mixed_oe_next;
      mixed_sel_reg  <= mixed_sel_next;
      in_one_sel_reg <= in_one_sel_next;
      in_two_sel_reg <= in_two_sel_next;
      periph_in_reg  <= {six_lvl[0], six_lvl[1], six_lvl[2], six_lvl[3], six_lvl[4]};
    end
  end
  assign six_pin_out = six_out_reg;
  assign six_pin_oe = six_oe_reg;
  assign mixed_pin_out = mixed_out_reg;
  assign mixed_pin_oe = mixed_oe_reg;
  assign mixed_lcd_sel = mixed_sel_reg;
  assign input_one_lcd_sel = in_one_sel_reg; // R15
  assign input_two_lcd_sel = in_two_sel_reg; // R17
  assign periph_in = gpio_pkg::periph_in_type'(periph_in_reg); // R03 R04 R06
  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_six_upper_zero: assert property ( // R01
    setup_ph && !pwrite && (hit_six_data || hit_six_dir) |=> prdata[31:6] == 26'h0)
    else $error("six-pin upper bits not zero");
  chk_soft_reset_keep: assert property ( // R02
    !other_reset_n |=> six_data_reg == $past(six_data_reg)
      && six_dir_reg == gpio_pkg::SIX_DIR_RST)
    else $error("soft reset disturbed six-pin data or direction");
  chk_mixed_reset: assert property ( // R14
    !other_reset_n |=> mixed_data_reg == gpio_pkg::MIXED_DATA_RST
      && mixed_dir_reg == gpio_pkg::DIR_RST)
    else $error("mixed port reset values wrong");
  chk_lcd_override: assert property ( // R13
    lcd_se_reg[0] |=> mixed_pin_oe[4:0] == 5'h00)
    else $error("mixed pin driven under LCD control");
  chk_upper_inputs: assert property ( // R09
    mixed_pin_oe[7:5] == 3'h0)
    else $error("mixed upper pin driven");
  chk_dir_drive: assert property ( // R09
    !lcd_se_reg[0] && !mixed_dir_reg[2] |=> mixed_pin_oe[2]
      && mixed_pin_out[2] == $past(mixed_data_reg[2]))
    else $error("mixed pin 2 not driven from latch");
  chk_read_pins: assert property ( // R19
    setup_ph && !pwrite && hit_mixed_data |=> prdata[7:0] == $past(mixed_lvl))
    else $error("read did not return pin levels");
  chk_sdo_drive: assert property ( // R07
    spi_on |=> six_pin_oe[5] && six_pin_out[5] == $past(periph_ctrl.serial_data_out_pin))
    else $error("serial data out not on pin 5");
  chk_osc_input: assert property ( // R03
    periph_ctrl.timer_osc_en |=> six_pin_oe[1:0] == 2'h0)
    else $error("oscillator pins driven");
  chk_group_sel: assert property ( // R16
    lcd_se_reg[6] && lcd_se_reg[1] |=> input_one_lcd_sel[7] && input_one_lcd_sel[0])
    else $error("input one group select wrong");
  // ==========================================================
  // Checks on latches and reads
  chk_mixed_latch: assert property ( // R19
    wr_en && hit_mixed_data && other_reset_n |=> mixed_data_reg == $past(pwdata[7:0]))
    else $error("mixed latch not loaded");
  chk_six_latch: assert property ( // R19
    wr_en && hit_six_data && other_reset_n |=> six_data_reg == $past(pwdata[5:0]))
    else $error("six-pin latch not loaded");
  chk_dir_plain: assert property ( // R21
    wr_en && hit_six_dir && other_reset_n |=> six_dir_reg == $past(pwdata[5:0]))
    else $error("six-pin direction not stored as written");
  chk_six_read: assert property ( // R19
    setup_ph && !pwrite && hit_six_data |=> prdata[5:0] == $past(six_lvl))
    else $error("six-pin read not pin levels");
  chk_six_dir_top: assert property ( // R01
    setup_ph && !pwrite && hit_six_dir |=> prdata[7:0] == {2'h0, $past(six_dir_reg)})
    else $error("six-pin direction read wrong");
  chk_in_one_read: assert property ( // R15
    setup_ph && !pwrite && hit_in_one_data |=> prdata[7:0] == $past(in_one_lvl))
    else $error("input one read not pin levels");
  chk_in_two_read: assert property ( // R17
    setup_ph && !pwrite && hit_in_two_data |=> prdata[7:0] == $past(in_two_lvl))
    else $error("input two read not pin levels");
  chk_lcd_soft_reset: assert property ( // R11
    !other_reset_n |=> lcd_se_reg == gpio_pkg::LCD_SE_RST)
    else $error("segment enable not reset to ones");
  // ==========================================================
  // Checks on six-pin peripheral sharing
  chk_osc_pins_in: assert property ( // R03
    1'b1 |=> periph_in.timer_ext_clock_in == $past(six_lvl[0])
      && periph_in.timer_osc_in == $past(six_lvl[1]))
    else $error("timer pins not passed to peripheral");
  chk_capture_in: assert property ( // R04
    periph_ctrl.ccp_capture_en && !periph_ctrl.ccp_out_en |=> !six_pin_oe[2]
      && periph_in.capture_in == $past(six_lvl[2]))
    else $error("capture pin not an input");
  chk_ccp_drive: assert property ( // R04
    periph_ctrl.ccp_out_en |=> six_pin_oe[2] && six_pin_out[2] == $past(periph_ctrl.ccp_out))
    else $error("compare output not on pin 2");
  chk_sck_pin: assert property ( // R05
    periph_ctrl.ssp_en |=> six_pin_oe[3] == $past(periph_ctrl.sck_drive)
      && six_pin_out[3] == $past(periph_ctrl.sck_out))
    else $error("serial clock not on pin 3");
  chk_sck_in: assert property ( // R05
    1'b1 |=> periph_in.sck_in == $past(six_lvl[3]))
    else $error("serial clock level not passed in");
  chk_sdi_input: assert property ( // R06
    spi_on |=> !six_pin_oe[4] && periph_in.serial_data_in_pin == $past(six_lvl[4]))
    else $error("serial data in pin driven");
  chk_sda_low: assert property ( // R06
    i2c_on |=> six_pin_oe[4] == $past(periph_ctrl.sda_drive_low) && !six_pin_out[4])
    else $error("data line not open drain");
  chk_serial_idle: assert property ( // R21
    !periph_ctrl.ssp_en |=> six_pin_oe[5:3] == ~$past(six_dir_reg[5:3]))
    else $error("serial pins ignore direction");
  chk_osc_idle: assert property ( // R21
    !periph_ctrl.timer_osc_en |=> six_pin_oe[1:0] == ~$past(six_dir_reg[1:0]))
    else $error("timer pins ignore direction");
  chk_pin5_latch: assert property ( // R07
    !spi_on |=> six_pin_out[5] == $past(six_data_reg[5]))
    else $error("pin 5 not driven from latch");
  // ==========================================================
  // Checks on LCD selects and mixed pins
  chk_upper_sel: assert property ( // R10
    1'b1 |=> mixed_lcd_sel[7:5] == {3{$past(lcd_se_reg[7])}})
    else $error("mixed upper select wrong");
  chk_lower_sel: assert property ( // R20
    1'b1 |=> mixed_lcd_sel[4:0] == {5{$past(lcd_se_reg[0])}})
    else $error("mixed lower select wrong");
  chk_one_groups: assert property ( // R16
    1'b1 |=> input_one_lcd_sel == {$past(lcd_se_reg[6]), {3{$past(lcd_se_reg[2])}},
      {4{$past(lcd_se_reg[1])}}})
    else $error("input one groups wrong");
  chk_two_groups: assert property ( // R18
    1'b1 |=> input_two_lcd_sel == {{4{$past(lcd_se_reg[4])}}, {4{$past(lcd_se_reg[3])}}})
    else $error("input two groups wrong");
  chk_mixed_drive: assert property ( // R13
    1'b1 |=> mixed_pin_oe[4:0] == (~$past(mixed_dir_reg[4:0])
      & ~{5{$past(lcd_se_reg[0])}}))
    else $error("mixed drive ignores select");
  chk_mixed_out: assert property ( // R19
    1'b1 |=> mixed_pin_out == $past(mixed_data_reg))
    else $error("mixed pins not driven from latch");
endmodule

// File: pin_world.sv
// Board-side model of the six-pin and mixed port pins of the LCD-shared port block
`timescale 1ns/1ps
module pin_world (
  input  wire logic [5:0] six_pin_out,
  input  wire logic [5:0] six_pin_oe,
  input  wire logic [7:0] mixed_pin_out,
  input  wire logic [7:0] mixed_pin_oe,
  input  wire logic [5:0] ext_six,
  input  wire logic [7:0] ext_mixed,
  output logic      [5:0] six_pin_in,
  output logic      [7:0] mixed_pin_in
);
  // ==========================================================
  // Pin level: device drive wins, board drive elsewhere
  assign six_pin_in   = (six_pin_oe & six_pin_out) | (~six_pin_oe & ext_six);
  assign mixed_pin_in = (mixed_pin_oe & mixed_pin_out) | (~mixed_pin_oe & ext_mixed);
endmodule

// File: testbench.sv
// Self-checking bench for the LCD-shared port block
`timescale 1ns/1ps
module testbench;
  logic                      pclk, presetn, other_reset_n, psel, penable, pwrite;
  logic                      pready, pslverr, er;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [5:0]                six_pin_in, six_pin_out, six_pin_oe, ext_six;
  logic [7:0]                mixed_pin_in, mixed_pin_out, mixed_pin_oe, ext_mixed;
  logic [7:0]                input_one_pin_in, input_two_pin_in;
  logic [7:0]                mixed_lcd_sel, input_one_lcd_sel, input_two_lcd_sel;
  gpio_pkg::periph_ctrl_type periph_ctrl;
  gpio_pkg::periph_in_type   periph_in;
  int                        fails, tests_run, cycles;
  localparam logic [7:0] exp_mix [8] = '{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0};
  localparam logic [7:0] exp_one [8] = '{8'h00, 8'h0f, 8'h70, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  localparam logic [7:0] exp_two [8] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'hf0, 8'h00, 8'h00, 8'h00};

  lcd_port_io u_lcd_port_io (.pclk(pclk), .presetn(presetn), .other_reset_n(other_reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .six_pin_in(six_pin_in),
    .six_pin_out(six_pin_out), .six_pin_oe(six_pin_oe), .mixed_pin_in(mixed_pin_in),
    .mixed_pin_out(mixed_pin_out), .mixed_pin_oe(mixed_pin_oe),
    .input_one_pin_in(input_one_pin_in), .input_two_pin_in(input_two_pin_in),
    .periph_ctrl(periph_ctrl), .periph_in(periph_in), .mixed_lcd_sel(mixed_lcd_sel),
    .input_one_lcd_sel(input_one_lcd_sel), .input_two_lcd_sel(input_two_lcd_sel));
  pin_world u_pin_world (.six_pin_out(six_pin_out), .six_pin_oe(six_pin_oe),
    .mixed_pin_out(mixed_pin_out), .mixed_pin_oe(mixed_pin_oe), .ext_six(ext_six),
    .ext_mixed(ext_mixed), .six_pin_in(six_pin_in), .mixed_pin_in(mixed_pin_in));

  // ==========================================================
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_por;
    rd_chk("six_dir", 12'h21c, 32'h3f);
    rd_chk("mixed_dir", 12'h220, 32'hff);
    rd_chk("lcd_se", 12'h434, 32'hff);
    check("mixed_oe", mixed_pin_oe, 8'h00);
    check("mixed_out", mixed_pin_out, 8'h00);
    check("sel", {mixed_lcd_sel, input_one_lcd_sel, input_two_lcd_sel}, 24'hffffff);
    apb(1'b0, 12'h3fc, 32'h0);
    check("unmapped_err", er, 1'b1);
    apb(1'b0, 12'h01d, 32'h0);
    check("misaligned_err", er, 1'b1);
    $display("test por done");
  endtask
  task automatic t_six;
    apb(1'b1, 12'h21c, 32'hff);
    rd_chk("six_dir_top", 12'h21c, 32'h3f);
    ext_six <= 6'h0b;
    tick(4);
    check("periph_in", periph_in, 5'h1a);
    rd_chk("six_data_pins", 12'h01c, 32'h0b);
    apb(1'b1, 12'h21c, 32'h00);
    apb(1'b1, 12'h01c, 32'h00);
    periph_ctrl.timer_osc_en <= 1'b1;
    tick(2);
    check("osc_oe", six_pin_oe, 6'h3c);
    periph_ctrl.ccp_capture_en <= 1'b1;
    tick(2);
    check("capture_oe", six_pin_oe, 6'h38);
    periph_ctrl.ccp_out_en <= 1'b1;
    periph_ctrl.ccp_out <= 1'b1;
    tick(2);
    check("ccp_out", six_pin_out, 6'h04);
    periph_ctrl.ssp_en <= 1'b1;
    periph_ctrl.sck_drive <= 1'b1;
    periph_ctrl.sck_out <= 1'b1;
    periph_ctrl.serial_data_out_pin <= 1'b1;
    tick(2);
    check("spi_oe", six_pin_oe, 6'h2c);
    check("spi_out", six_pin_out, 6'h2c);
    periph_ctrl.ssp_i2c <= 1'b1;
    periph_ctrl.sda_drive_low <= 1'b1;
    tick(2);
    check("i2c_oe", six_pin_oe, 6'h3c);
    check("i2c_out", six_pin_out, 6'h0c);
    periph_ctrl <= '0;
    $display("test six done");
  endtask
  task automatic t_mixed;
    apb(1'b1, 12'h434, 32'h00);
    apb(1'b1, 12'h220, 32'h00);
    apb(1'b1, 12'h020, 32'hff);
    ext_mixed <= 8'h40;
    tick(4);
    check("mixed_oe", mixed_pin_oe, 8'h1f);
    check("mixed_out", mixed_pin_out[4:0], 5'h1f);
    rd_chk("mixed_pins", 12'h020, 32'h5f);
    apb(1'b1, 12'h434, 32'h01);
    tick(2);
    check("lcd_override", mixed_pin_oe, 8'h00);
    $display("test mixed done");
  endtask
  task automatic t_groups;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h434, 32'h1 << i);
      tick(2);
      check("mix_sel", mixed_lcd_sel, exp_mix[i]);
      check("one_sel", input_one_lcd_sel, exp_one[i]);
      check("two_sel", input_two_lcd_sel, exp_two[i]);
    end
    $display("test groups done");
  endtask
  task automatic t_inputs;
    apb(1'b1, 12'h434, 32'h00);
    input_one_pin_in <= 8'ha5;
    input_two_pin_in <= 8'h3c;
    apb(1'b1, 12'h024, 32'h00);
    tick(4);
    rd_chk("in_one", 12'h024, 32'ha5);
    rd_chk("in_two", 12'h41c, 32'h3c);
    $display("test inputs done");
  endtask
  task automatic t_other;
    apb(1'b1, 12'h21c, 32'h00);
    apb(1'b1, 12'h01c, 32'h2a);
    @(posedge pclk);
    other_reset_n <= 1'b0;
    @(posedge pclk);
    other_reset_n <= 1'b1;
    tick(2);
    check("six_kept", six_pin_out, 6'h2a);
    check("six_oe", six_pin_oe, 6'h00);
    check("mixed_out_rst", mixed_pin_out, 8'h00);
    check("sel", {mixed_lcd_sel, input_one_lcd_sel}, 16'hffff);
    rd_chk("mixed_dir", 12'h220, 32'hff);
    rd_chk("lcd_se", 12'h434, 32'hff);
    $display("test other reset done");
  endtask

  initial begin
    presetn = 1'b0;
    other_reset_n = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_six = 6'h00;
    ext_mixed = 8'h00;
    input_one_pin_in = 8'h00;
    input_two_pin_in = 8'h00;
    periph_ctrl = '0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    tick(5);
    presetn <= 1'b1;
    t_por();
    t_six();
    t_mixed();
    t_groups();
    t_inputs();
    t_other();
    finish_test();
  end
endmodule
